// [design/owc_map.svh]
`ifndef OWC_MAP_SVH
`define OWC_MAP_SVH
// Register byte offsets.
`define OWC_OFF_LOWER_CTL 8'h00
`define OWC_OFF_UPPER_CTL 8'h04
`define OWC_OFF_THR_LOW 8'h08
`define OWC_OFF_THR_HIGH 8'h0c
`define OWC_OFF_SYS_CLK 8'h10
`define OWC_OFF_IRQ_STATUS 8'h14
`define OWC_OFF_IRQ_MASK 8'h18
`define OWC_OFF_COUNT 8'h1c
// Field positions.
`define OWC_SYS_HIGH_EN_BIT 7
`define OWC_SYS_LOW_EN_BIT 6
`define OWC_SYS_LOW_SEL_BIT 5
`define OWC_IRQ_MATCH_BIT 0
// Mode and source codes.
`define OWC_MODE_WARMUP 3'h5
`define OWC_MODE_16BIT 3'h3
`define OWC_SRC_LOW 3'h4
`define OWC_SRC_HIGH 3'h6
// Reset values.
`define OWC_RST_CTL 8'h00
`define OWC_RST_THR 8'h00
`define OWC_RST_SYS_CLK 8'h00
`define OWC_RST_IRQ 8'h00
`endif

// [design/owc_pkg.sv]
package owc_pkg;
  typedef struct packed {
    logic init;
    logic [2:0] src;
    logic run;
    logic [2:0] mode;
  } owc_ctl_type;
  typedef struct packed {
    logic high_en;
    logic low_en;
    logic low_sel;
    logic [4:0] spare;
  } owc_sys_clk_type;
  typedef enum logic [1:0] {
    OWC_BUS_IDLE = 2'b01,
    OWC_BUS_ANSWER = 2'b10
  } owc_bus_state_type;
endpackage

// [design/owc_warmup_counter.sv]
`timescale 1ns/100ps
`default_nettype none
`include "owc_map.svh"
// Notes on behaviour
// - In warm-up the two 8-bit counters chain into one 16-bit up-counter.
// - Match detection uses only the upper threshold byte, not the lower.
// - A running count rises; a match clears it and sets the status bit, raising the interrupt only if unmasked.
// - On the low clock 0100H gives 256 ticks, about 7.81 ms; FF00H 1.99 s.
// - On the high clock the span runs from 256 to 65536 ticks; a zero upper byte gives 65536.
// - Upper control 05H picks warm-up; lower 43H the low clock, 63H high.
// - Upper control bit 3 set runs the cascaded counter; clear stops it.
// - Clock control bit 7 enables high, bit 6 low, bit 5 selects low.
// - Reset sets the upper timer output flop to 1.
module owc_warmup_counter #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Avalon-MM slave.
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Source clock pins, asynchronous to the system clock.
  input wire logic high_clock_i,
  input wire logic low_clock_i,
  // Oscillator controls and timer pin.
  output logic high_osc_en_o,
  output logic low_osc_en_o,
  output logic sys_clk_low_sel_o,
  output logic upper_timer_pin_o,
  // Interrupt.
  output logic warmup_match_irq_o
);

  if (ADDR_W < 5) begin : g_addr_w_check
    $error("ADDR_W too small for the register map.");
  end

  owc_pkg::owc_bus_state_type bus_state_q;
  owc_pkg::owc_ctl_type lower_timer_control_q;
  owc_pkg::owc_ctl_type upper_timer_control_q;
  owc_pkg::owc_sys_clk_type system_clock_control_q;
  logic [7:0] threshold_low_byte_q;
  logic [7:0] threshold_high_byte_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [15:0] count_q;
  logic [15:0] count_inc;
  logic [31:0] readdata_q;
  logic waitrequest_q;
  logic irq_q;
  logic pin_q;
  logic [2:0] high_sync_q;
  logic [2:0] low_sync_q;
  logic high_level_q;
  logic low_level_q;
  logic high_rise;
  logic low_rise;
  logic src_tick;
  logic warm_run;
  logic match;
  logic wr_acc;
  logic rd_acc;
  logic [7:0] byte_addr;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  assign byte_addr = 8'(avs_address_i);
  assign wr_acc = avs_write_i && !waitrequest_q;
  assign rd_acc = avs_read_i && !waitrequest_q;

  // One wait cycle on every access keeps the read mux off the bus path.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_state_q <= owc_pkg::OWC_BUS_IDLE;
      waitrequest_q <= 1'b1;
    end else begin
      case (bus_state_q)
        owc_pkg::OWC_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state_q <= owc_pkg::OWC_BUS_ANSWER;
            waitrequest_q <= 1'b0;
          end
        end
        owc_pkg::OWC_BUS_ANSWER: begin
          bus_state_q <= owc_pkg::OWC_BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
        default: begin
          bus_state_q <= owc_pkg::OWC_BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read_i && waitrequest_q) begin
      if (hit(byte_addr, `OWC_OFF_LOWER_CTL)) begin
        readdata_q <= {24'h00_0000, lower_timer_control_q};
      end else if (hit(byte_addr, `OWC_OFF_UPPER_CTL)) begin
        readdata_q <= {24'h00_0000, upper_timer_control_q};
      end else if (hit(byte_addr, `OWC_OFF_THR_LOW)) begin
        readdata_q <= {24'h00_0000, threshold_low_byte_q};
      end else if (hit(byte_addr, `OWC_OFF_THR_HIGH)) begin
        readdata_q <= {24'h00_0000, threshold_high_byte_q};
      end else if (hit(byte_addr, `OWC_OFF_SYS_CLK)) begin
        readdata_q <= {24'h00_0000, system_clock_control_q};
      end else if (hit(byte_addr, `OWC_OFF_IRQ_STATUS)) begin
        readdata_q <= {24'h00_0000, irq_status_q | irq_set};
      end else if (hit(byte_addr, `OWC_OFF_IRQ_MASK)) begin
        readdata_q <= {24'h00_0000, irq_mask_q};
      end else if (hit(byte_addr, `OWC_OFF_COUNT)) begin
        readdata_q <= {16'h0000, count_q};
      end else begin
        readdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lower_timer_control_q <= `OWC_RST_CTL;
      upper_timer_control_q <= `OWC_RST_CTL;
      threshold_low_byte_q <= `OWC_RST_THR;
      threshold_high_byte_q <= `OWC_RST_THR;
      irq_mask_q <= `OWC_RST_IRQ;
    end else if (wr_acc && avs_byteenable_i[0]) begin
      if (hit(byte_addr, `OWC_OFF_LOWER_CTL)) begin
        lower_timer_control_q <= avs_writedata_i[7:0];
      end else if (hit(byte_addr, `OWC_OFF_UPPER_CTL)) begin
        upper_timer_control_q <= avs_writedata_i[7:0];
      end else if (hit(byte_addr, `OWC_OFF_THR_LOW)) begin
        threshold_low_byte_q <= avs_writedata_i[7:0];
      end else if (hit(byte_addr, `OWC_OFF_THR_HIGH)) begin
        threshold_high_byte_q <= avs_writedata_i[7:0];
      end else if (hit(byte_addr, `OWC_OFF_IRQ_MASK)) begin
        irq_mask_q <= avs_writedata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      system_clock_control_q <= `OWC_RST_SYS_CLK;
    end else if (wr_acc && avs_byteenable_i[0] &&
                 hit(byte_addr, `OWC_OFF_SYS_CLK)) begin
      system_clock_control_q <= avs_writedata_i[7:0];
    end
  end

  assign high_osc_en_o = system_clock_control_q.high_en;
  assign low_osc_en_o = system_clock_control_q.low_en;
  assign sys_clk_low_sel_o = system_clock_control_q.low_sel;

  // Source pins may glitch, so a level counts only once two stages agree.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      high_sync_q <= 3'h0;
      low_sync_q <= 3'h0;
      high_level_q <= 1'b0;
      low_level_q <= 1'b0;
    end else begin
      high_sync_q <= {high_sync_q[1:0], high_clock_i};
      low_sync_q <= {low_sync_q[1:0], low_clock_i};
      if (high_sync_q[1] == high_sync_q[2]) begin
        high_level_q <= high_sync_q[2];
      end
      if (low_sync_q[1] == low_sync_q[2]) begin
        low_level_q <= low_sync_q[2];
      end
    end
  end

  assign high_rise = (high_sync_q[1] == high_sync_q[2]) &&
                     high_sync_q[2] && !high_level_q;
  assign low_rise = (low_sync_q[1] == low_sync_q[2]) &&
                    low_sync_q[2] && !low_level_q;

  always_comb begin
    if (lower_timer_control_q.src == `OWC_SRC_HIGH) begin
      src_tick = high_rise;
    end else if (lower_timer_control_q.src == `OWC_SRC_LOW) begin
      src_tick = low_rise;
    end else begin
      src_tick = 1'b0;
    end
  end

  assign warm_run = upper_timer_control_q.run &&
                    (upper_timer_control_q.mode == `OWC_MODE_WARMUP);
  assign count_inc = count_q + 16'h0001;
  assign match = warm_run && src_tick &&
                 (count_inc == {threshold_high_byte_q, 8'h00});

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q <= 16'h0000;
    end else if (!warm_run) begin
      count_q <= 16'h0000;
    end else if (match) begin
      count_q <= 16'h0000;
    end else if (src_tick) begin
      count_q <= count_inc;
    end
  end

  assign irq_set = match ? 8'h01 << `OWC_IRQ_MATCH_BIT : 8'h00;
  assign irq_clr = (rd_acc && hit(byte_addr, `OWC_OFF_IRQ_STATUS)) ?
                   8'hff : 8'h00;

  // A match in the clearing cycle survives, since set beats clear.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status_q <= `OWC_RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // The flop never toggles in warm-up; it takes the inverse of its init bit at rest.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_q <= 1'b1;
    end else if (!upper_timer_control_q.run) begin
      pin_q <= ~upper_timer_control_q.init;
    end
  end

  assign avs_readdata_o = readdata_q;
  assign avs_waitrequest_o = waitrequest_q;
  assign upper_timer_pin_o = pin_q;
  assign warmup_match_irq_o = irq_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence seq_tick_no_match;
    warm_run && src_tick && !match;
  endsequence

  chk_count_step: assert property (
    seq_tick_no_match |=> count_q == $past(count_q) + 16'h0001)
    else $error("Count did not step on a source tick.");

  chk_match_upper_byte: assert property (
    warm_run && src_tick |-> match == (count_q[7:0] == 8'hff &&
      count_q[15:8] == threshold_high_byte_q - 8'h01))
    else $error("Match ignored the upper threshold byte.");

  sequence seq_match_flagged;
    count_q == 16'h0000 && irq_status_q[0];
  endsequence

  chk_match_clear_irq: assert property (
    match |=> seq_match_flagged ##1
      warmup_match_irq_o == $past(irq_mask_q[0]))
    else $error("Match did not clear the count or raise the status.");

  chk_stop_holds_zero: assert property (
    !warm_run |=> count_q == 16'h0000 && !$rose(irq_status_q[0]))
    else $error("Stopped counter moved or raised an interrupt.");

  chk_source_select: assert property (
    warm_run && lower_timer_control_q.src == `OWC_SRC_LOW && !low_rise
      |=> $stable(count_q))
    else $error("Count moved without a low clock edge.");

  chk_run_bit_stop: assert property (
    $fell(upper_timer_control_q.run) |=> count_q == 16'h0000)
    else $error("Clearing the run bit did not stop the counter.");

  chk_sys_clk_write: assert property (
    wr_acc && avs_byteenable_i[0] && hit(byte_addr, `OWC_OFF_SYS_CLK)
      |=> high_osc_en_o == $past(avs_writedata_i[7]) &&
          low_osc_en_o == $past(avs_writedata_i[6]) &&
          sys_clk_low_sel_o == $past(avs_writedata_i[5]))
    else $error("Clock control bits not taken from the write.");

  chk_flop_run_stable: assert property (
    upper_timer_control_q.run |=> $stable(upper_timer_pin_o))
    else $error("Timer pin toggled while the counter ran.");

  chk_irq_level: assert property (
    (irq_status_q & irq_mask_q) != 8'h00 |=> warmup_match_irq_o)
    else $error("Unmasked status did not raise the interrupt.");

endmodule
`default_nettype wire

// [dv/owc_osc_model.sv]
`timescale 1ns/100ps
`default_nettype none
module owc_osc_model #(
  parameter real HIGH_HALF = 37.0,
  parameter real LOW_HALF = 43.0
) (
  // Oscillator enables.
  input wire logic high_en_i,
  input wire logic low_en_i,
  // Oscillator clocks.
  output logic high_clk_o,
  output logic low_clk_o
);
  // Oscillator gating.
  // A stopped oscillator rests low, so no stray tick reaches the counter.
  initial begin
    high_clk_o = 1'b0;
    forever begin
      #(HIGH_HALF);
      high_clk_o = high_en_i ? ~high_clk_o : 1'b0;
    end
  end
  initial begin
    low_clk_o = 1'b0;
    forever begin
      #(LOW_HALF);
      low_clk_o = low_en_i ? ~low_clk_o : 1'b0;
    end
  end
endmodule
`default_nettype wire

// [dv/owc_warmup_counter_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "owc_map.svh"
module owc_warmup_counter_tb;
  logic clk, arst_n, rd, wr, hclk, lclk, hen, len, lsel, pin, irq, wreq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, got, v;
  logic [3:0] be;
  logic [31:0] seed = 32'h01e4;
  logic [7:0] offs [3] = '{8'h00, 8'h08, 8'h0c};
  int miscompares = 0;
  int total_checks = 0;
  int lticks = 0;
  int hticks = 0;

  owc_warmup_counter owc_warmup_counter_i (
    .clk_sys_i(clk), .arst_n_i(arst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .high_clock_i(hclk), .low_clock_i(lclk),
    .high_osc_en_o(hen), .low_osc_en_o(len), .sys_clk_low_sel_o(lsel),
    .upper_timer_pin_o(pin), .warmup_match_irq_o(irq));
  owc_osc_model owc_osc_model_i (.high_en_i(hen), .low_en_i(len),
    .high_clk_o(hclk), .low_clk_o(lclk));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge lclk) lticks++;
  always @(posedge hclk) hticks++;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // A zero upper byte wraps the full 16-bit range.
  function automatic int ticks_for(input logic [7:0] n);
    return (n == 8'h00) ? 65536 : 256 * n;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(got, exp);
  endtask

  task automatic outs(input logic [2:0] exp);
    repeat (2) @(posedge clk);
    chk({hen, len, lsel}, exp);
  endtask

  task automatic warm(input logic [7:0] ctl, input logic [7:0] n,
                      input logic m);
    int t;
    int e;
    e = ticks_for(n);
    acc(1'b1, `OWC_OFF_LOWER_CTL, {24'h0, ctl});
    acc(1'b1, `OWC_OFF_UPPER_CTL, 32'h05);
    acc(1'b1, `OWC_OFF_THR_LOW, xs() & 32'hff);
    acc(1'b1, `OWC_OFF_THR_HIGH, {24'h0, n});
    acc(1'b1, `OWC_OFF_IRQ_MASK, {31'h0, m});
    acc(1'b1, `OWC_OFF_UPPER_CTL, 32'h0d);
    lticks = 0;
    hticks = 0;
    t = 0;
    while (irq !== 1'b1 && t <= e + 2) begin
      @(posedge clk);
      t = ctl[5] ? hticks : lticks;
    end
    chk(irq, m);
    if (m) chk(t >= e - 1 && t <= e, 1);
    acc(1'b1, `OWC_OFF_UPPER_CTL, 32'h05);
    rdc(`OWC_OFF_IRQ_STATUS, 32'h1);
    rdc(`OWC_OFF_COUNT, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq, 0);
  endtask

  task automatic summarize();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    summarize();
  end

  initial begin
    arst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    be = 4'hf;
    repeat (16) @(posedge clk);
    chk({pin, irq, hen, len, lsel}, 5'h10);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 32; a += 4) rdc(a[7:0], 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = xs();
      acc(1'b1, offs[i], v);
      rdc(offs[i], v & 32'hff);
    end
    be <= 4'he;
    acc(1'b1, `OWC_OFF_THR_HIGH, 32'h5a);
    be <= 4'hf;
    rdc(`OWC_OFF_THR_HIGH, v & 32'hff);
    acc(1'b1, 8'h20, 32'hff);
    rdc(8'h20, 32'h0);
    acc(1'b1, `OWC_OFF_UPPER_CTL, 32'h80);
    repeat (2) @(posedge clk);
    chk(pin, 0);
    acc(1'b1, `OWC_OFF_UPPER_CTL, 32'h05);
    repeat (2) @(posedge clk);
    chk(pin, 1);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'h80);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'hc0);
    outs(3'b110);
    warm(8'h43, 8'h01, 1'b1);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'he0);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'h60);
    outs(3'b011);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'he0);
    outs(3'b111);
    warm(8'h63, 8'h02, 1'b1);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'hc0);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'h80);
    outs(3'b100);
    acc(1'b1, `OWC_OFF_SYS_CLK, 32'hc0);
    warm(8'h43, 8'h01, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
